// >>> core/timer_defines.vh
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
// ----------------------------------------
// Register map.
// ----------------------------------------
`define ADDR_CONTROL_ZERO 4'h0
`define ADDR_CONTROL_ONE 4'h1
`define ADDR_COUNT_LOW 4'h2
`define ADDR_COUNT_HIGH 4'h3
`define ADDR_COMPARE_A_LOW 4'h4
`define ADDR_COMPARE_A_HIGH 4'h5
`define ADDR_FLAGS 4'h6
`define ADDR_PIN 4'h7
// ----------------------------------------
// Control zero fields.
// ----------------------------------------
`define BIT_RUN 3
`define BIT_P_HIGH 2
`define BIT_P_LOW 0
// ----------------------------------------
// Control one fields.
// ----------------------------------------
`define BIT_MODE_HIGH 7
`define BIT_MODE_LOW 6
`define BIT_FUNC_HIGH 5
`define BIT_FUNC_LOW 4
`define BIT_LEVEL 3
`define BIT_INVERT 2
`define BIT_SWAP 1
`define BIT_CLEAR_SEL 0
`define MODE_COMPARE 2'h0
`define MODE_UNDEFINED 2'h1
`define MODE_PWM 2'h2
`define MODE_COUNTER 2'h3
`define FUNC_HOLD 2'h0
`define FUNC_LOW 2'h1
`define FUNC_HIGH 2'h2
`define FUNC_TOGGLE 2'h3
`define CONTROL_RESET 8'h00
`define COUNT_MAX 10'h3ff
`endif

// >>> core/compact_timer.v
`timescale 1ns/1ps
`include "timer_defines.vh"
module compact_timer (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  output reg timer_output_pin,
  output reg compare_a_match_flag,
  output reg compare_p_match_flag
);
  // ----------------------------------------
  // Registers.
  // ----------------------------------------
  reg [7:0] control_zero;
  reg [7:0] timer0_control_one;
  reg [9:0] compare_a_value;
  reg [9:0] count;
  reg run_prev;
  reg pin_state;
  reg pwm_state;
  wire timer_run_control = control_zero[`BIT_RUN];
  wire [2:0] compare_p_value = control_zero[`BIT_P_HIGH:`BIT_P_LOW];
  wire [1:0] mode = timer0_control_one[`BIT_MODE_HIGH:`BIT_MODE_LOW];
  wire [1:0] pin_function = timer0_control_one[`BIT_FUNC_HIGH:`BIT_FUNC_LOW];
  wire output_level_select = timer0_control_one[`BIT_LEVEL];
  wire output_invert_select = timer0_control_one[`BIT_INVERT];
  wire period_duty_swap = timer0_control_one[`BIT_SWAP];
  wire clear_source_select = timer0_control_one[`BIT_CLEAR_SEL];
  wire run_rise = timer_run_control & ~run_prev;
  wire running = timer_run_control & run_prev;
  // ----------------------------------------
  // Comparators.
  // ----------------------------------------
  wire match_a = running && (count == compare_a_value);
  wire match_p = running && (count[9:7] == compare_p_value);
  wire overflow = running && (count == `COUNT_MAX);
  wire is_pwm = (mode == `MODE_PWM);
  wire is_compare = (mode == `MODE_COMPARE);
  wire is_counter = (mode == `MODE_COUNTER);
  wire a_zero = (compare_a_value == 10'h000);
  reg clear_now;
  reg set_a;
  reg set_p;
  reg pwm_period;
  reg pwm_duty;
  always @* begin
    clear_now = 1'b0;
    set_a = 1'b0;
    set_p = 1'b0;
    pwm_period = 1'b0;
    pwm_duty = 1'b0;
    if (is_pwm) begin
      set_a = match_a;
      set_p = match_p;
      pwm_period = period_duty_swap ? match_a : match_p;
      pwm_duty = period_duty_swap ? match_p : match_a;
      clear_now = pwm_period | overflow;
    end else if (clear_source_select) begin
      set_a = match_a & ~a_zero;
      clear_now = (match_a & ~a_zero) | overflow;
    end else begin
      set_a = match_a;
      set_p = match_p & (compare_p_value != 3'h0);
      clear_now = (match_p & (compare_p_value != 3'h0)) | overflow;
    end
  end
  // ----------------------------------------
  // Compare-mode pin state.
  // ----------------------------------------
  reg next_pin_state;
  always @* begin
    next_pin_state = pin_state;
    if (run_rise) begin
      next_pin_state = output_level_select;
    end else if (is_compare && set_a) begin
      case (pin_function)
        `FUNC_HOLD: next_pin_state = pin_state;
        `FUNC_LOW: next_pin_state = 1'b0;
        `FUNC_HIGH: next_pin_state = 1'b1;
        `FUNC_TOGGLE: next_pin_state = ~pin_state;
        default: next_pin_state = pin_state;
      endcase
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      pin_state <= 1'b0;
    end else begin
      pin_state <= next_pin_state;
    end
  end
  // ----------------------------------------
  // Register write decode.
  // ----------------------------------------
  wire write_control_zero = wr && (addr == `ADDR_CONTROL_ZERO);
  wire write_control_one = wr && (addr == `ADDR_CONTROL_ONE);
  wire write_a_low = wr && (addr == `ADDR_COMPARE_A_LOW);
  wire write_a_high = wr && (addr == `ADDR_COMPARE_A_HIGH);
  wire write_flags = wr && (addr == `ADDR_FLAGS);
  wire clear_a_request = write_flags && wdata[0];
  wire clear_p_request = write_flags && wdata[1];
  // ----------------------------------------
  // Control registers.
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      control_zero <= `CONTROL_RESET;
    end else if (write_control_zero) begin
      control_zero <= wdata;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      timer0_control_one <= `CONTROL_RESET;
    end else if (write_control_one) begin
      timer0_control_one <= wdata;
    end
  end
  // ----------------------------------------
  // Compare A value.
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      compare_a_value <= 10'h000;
    end else begin
      if (write_a_low) begin
        compare_a_value[7:0] <= wdata;
      end
      if (write_a_high) begin
        compare_a_value[9:8] <= wdata[1:0];
      end
    end
  end
  // ----------------------------------------
  // Run edge tracking.
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= timer_run_control;
    end
  end
  // ----------------------------------------
  // Counter.
  // ----------------------------------------
  reg [9:0] next_count;
  always @* begin
    next_count = count;
    if (run_rise) begin
      next_count = 10'h000;
    end else if (running && clear_now) begin
      next_count = 10'h000;
    end else if (running) begin
      next_count = count + 10'h001;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      count <= 10'h000;
    end else begin
      count <= next_count;
    end
  end
  // ----------------------------------------
  // Waveform state.
  // ----------------------------------------
  reg next_pwm_state;
  always @* begin
    next_pwm_state = pwm_state;
    if (run_rise || pwm_period) begin
      next_pwm_state = 1'b1;
    end else if (pwm_duty) begin
      next_pwm_state = 1'b0;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      pwm_state <= 1'b0;
    end else begin
      pwm_state <= next_pwm_state;
    end
  end
  // ----------------------------------------
  // Match flags.
  // ----------------------------------------
  reg next_flag_a;
  reg next_flag_p;
  always @* begin
    next_flag_a = compare_a_match_flag;
    if (set_a) begin
      next_flag_a = 1'b1;
    end else if (clear_a_request) begin
      next_flag_a = 1'b0;
    end
  end
  always @* begin
    next_flag_p = compare_p_match_flag;
    if (set_p) begin
      next_flag_p = 1'b1;
    end else if (clear_p_request) begin
      next_flag_p = 1'b0;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      compare_a_match_flag <= 1'b0;
      compare_p_match_flag <= 1'b0;
    end else begin
      compare_a_match_flag <= next_flag_a;
      compare_p_match_flag <= next_flag_p;
    end
  end
  // ----------------------------------------
  // Output pin.
  // ----------------------------------------
  reg next_pin;
  always @* begin
    next_pin = 1'b0;
    if (is_pwm) begin
      case (pin_function)
        `FUNC_HOLD: next_pin = ~output_level_select;
        `FUNC_LOW: next_pin = output_level_select;
        `FUNC_HIGH: next_pin = pwm_state ? output_level_select : ~output_level_select;
        default: next_pin = ~output_level_select;
      endcase
      next_pin = next_pin ^ output_invert_select;
    end else if (is_compare) begin
      next_pin = pin_state ^ output_invert_select;
    end else begin
      next_pin = 1'b0;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= next_pin;
    end
  end
  // ----------------------------------------
  // Register read.
  // ----------------------------------------
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        `ADDR_CONTROL_ZERO: next_rdata = control_zero;
        `ADDR_CONTROL_ONE: next_rdata = timer0_control_one;
        `ADDR_COUNT_LOW: next_rdata = count[7:0];
        `ADDR_COUNT_HIGH: next_rdata = {6'h00, count[9:8]};
        `ADDR_COMPARE_A_LOW: next_rdata = compare_a_value[7:0];
        `ADDR_COMPARE_A_HIGH: next_rdata = {6'h00, compare_a_value[9:8]};
        `ADDR_FLAGS: next_rdata = {6'h00, compare_p_match_flag, compare_a_match_flag};
        `ADDR_PIN: next_rdata = {7'h00, pin_state};
        default: next_rdata = 8'h00;
      endcase
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule // compact_timer

// >>> bench/compact_timer_assertions.sv
`timescale 1ns/1ps
module compact_timer_checker (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire timer_output_pin,
  input wire compare_a_match_flag,
  input wire compare_p_match_flag
);
  // ----
  // Shadow copies of both control registers.
  // ----
  reg [7:0] c0;
  reg [7:0] c1;
  wire clr_a = wr && addr == 4'h6 && wdata[0];
  wire clr_p = wr && addr == 4'h6 && wdata[1];
  wire no_p = c1[7:6] == 2'h0 && c1[0];
  wire tc_mode = c1[7:6] == 2'h3;
  always @(posedge clk) begin
    if (rst || (wr && addr == 4'h0)) c0 <= rst ? 8'h00 : wdata;
    if (rst || (wr && addr == 4'h1)) c1 <= rst ? 8'h00 : wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("Read data not zero outside a read.");
  AST_RESET_OUT: assert property (disable iff (1'b0) rst |=> !timer_output_pin
    && !compare_a_match_flag && !compare_p_match_flag) else $error("Outputs not cleared.");
  AST_PIN_CAUSE: assert property ($changed(timer_output_pin) |-> compare_a_match_flag
    || $past(wr) || $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
    else $error("Pin changed without an A match.");
  AST_A_CLEAR: assert property ($fell(compare_a_match_flag) |-> $past(clr_a))
    else $error("A flag dropped without a clear.");
  AST_P_CLEAR: assert property ($fell(compare_p_match_flag) |-> $past(clr_p))
    else $error("P flag dropped without a clear.");
  AST_NO_P_FLAG: assert property ($rose(compare_p_match_flag) |-> !$past(no_p))
    else $error("P flag raised with A clearing.");
  AST_COUNTER_PIN: assert property (tc_mode [*3] |-> !timer_output_pin)
    else $error("Pin driven in counter mode.");
  AST_RUN_RELOAD: assert property (wr && addr == 4'h0 && wdata[3] && !c0[3]
    && c1[7:6] == 2'h0 |-> ##[2:3] timer_output_pin == (c1[3] ^ c1[2]))
    else $error("Pin not loaded with initial level.");
endmodule // compact_timer_checker
bind compact_timer compact_timer_checker chk_i (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .timer_output_pin(timer_output_pin),
  .compare_a_match_flag(compare_a_match_flag), .compare_p_match_flag(compare_p_match_flag));

// >>> bench/test_compact_timer.sv
`timescale 1ns/1ps
module test_compact_timer;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [7:0] rdata;
  wire pin;
  wire flag_a;
  wire flag_p;
  integer mismatches = 0;
  integer checks = 0;
  integer i;
  integer n;
  reg [7:0] c1v;
  reg [7:0] exp;
  always #12.5 clk = ~clk;
  compact_timer uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .timer_output_pin(pin), .compare_a_match_flag(flag_a),
    .compare_p_match_flag(flag_p));
  // ----
  // Bus and compare tasks.
  // ----
  task chk(input [7:0] seen, input [7:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
    end
  endtask
  task wreg(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [3:0] a, input [7:0] want);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, want);
    end
  endtask
  task wait_a;
    begin
      n = 0;
      while (flag_a !== 1'b1 && n < 40) begin
        @(negedge clk);
        n = n + 1;
      end
    end
  endtask
  task start(input [7:0] ctrl1, input [7:0] ctrl0);
    begin
      wreg(4'h0, 8'h00);
      wreg(4'h6, 8'h03);
      wreg(4'h1, ctrl1);
      wreg(4'h0, ctrl0);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  // ----
  // Test sequence.
  // ----
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rreg(4'h1, 8'h00);
    rreg(4'h8, 8'h00);
    wreg(4'h1, 8'hb5);
    rreg(4'h1, 8'hb5);
    wreg(4'h4, 8'h05);
    wreg(4'h5, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      c1v = {2'b00, i[1:0], ~i[1], i[2], 2'b01};
      start(c1v, 8'h08);
      repeat (3) @(negedge clk);
      chk({7'h00, pin}, {7'h00, c1v[3] ^ c1v[2]});
      wait_a;
      repeat (2) @(negedge clk);
      exp = {7'h00, c1v[2] ^ (c1v[5] ? (c1v[4] ? ~c1v[3] : 1'b1) : (c1v[4] ? 1'b0 : c1v[3]))};
      chk({7'h00, pin}, exp);
      chk({7'h00, flag_p}, 8'h00);
    end
    wreg(4'h4, 8'h00);
    start(8'h31, 8'h08);
    repeat (1100) @(negedge clk);
    chk({5'h00, pin, flag_p, flag_a}, 8'h00);
    wreg(4'h4, 8'h05);
    start(8'h30, 8'h09);
    repeat (300) @(negedge clk);
    rreg(4'h6, 8'h03);
    rreg(4'h3, 8'h00);
    start(8'ha9, 8'h09);
    repeat (3) @(negedge clk);
    chk({7'h00, pin}, 8'h01);
    wait_a;
    repeat (2) @(negedge clk);
    chk({7'h00, pin}, 8'h00);
    repeat (200) @(negedge clk);
    rreg(4'h6, 8'h03);
    start(8'hfc, 8'h08);
    wait_a;
    repeat (2) @(negedge clk);
    chk({6'h00, flag_a, pin}, 8'h02);
    tally_and_finish;
  end
endmodule // test_compact_timer
